//--- hdl/bfep_pkg.sv
package bfep_pkg;
    // configuration offsets (byte addresses, dword aligned)
    localparam logic [7:0] CFG_CMD_DW = 8'h04;
    localparam logic [7:0] CFG_BRCTL_DW = 8'h3c;
    localparam logic [7:0] CFG_CHIPCTL_DW = 8'h40;
    localparam logic [7:0] CFG_EXT_FIRST = 8'h40;
    // command register
    localparam int CMD_SERR_EN_BIT = 8;
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam logic [15:0] CMD_WMASK = 16'h0100;
    // bridge policy control bit positions
    localparam int BC_PARITY_BIT = 0;
    localparam int BC_SERR_FWD_BIT = 1;
    localparam int BC_ISA_BIT = 2;
    localparam int BC_VGA_BIT = 3;
    localparam int BC_MAMODE_BIT = 5;
    localparam logic [15:0] BC_RESET = 16'h0000;
    // bit 4 reserved, 7 and 10 and 15..12 not held here
    localparam logic [15:0] BC_WMASK = 16'h0b6f;
    // chip function control
    localparam int CC_PREFETCH_OFF_BIT = 4;
    localparam logic [7:0] CC_RESET = 8'h00;
    localparam logic [7:0] CC_WMASK = 8'h12;
    // master abort read data
    localparam logic [31:0] ABORT_READ_DATA = 32'hffffffff;
    // legacy video ranges
    localparam logic [31:0] VGA_MEM_LO = 32'h000a0000;
    localparam logic [31:0] VGA_MEM_HI = 32'h000bffff;
    localparam logic [31:0] VGA_IO1_LO = 32'h000003b0;
    localparam logic [31:0] VGA_IO1_HI = 32'h000003bb;
    localparam logic [31:0] VGA_IO2_LO = 32'h000003c0;
    localparam logic [31:0] VGA_IO2_HI = 32'h000003df;
    // legacy alias blocking: first 64K of io space, top 768 bytes of each 1K
    localparam logic [31:0] ISA_SPACE_TOP = 32'h0000ffff;
endpackage

//--- hdl/bfep_fwd_decode.sv
`timescale 1ns/1ps
module bfep_fwd_decode (
    input wire logic [31:0] addr,
    input wire logic isIo,
    input wire logic isMem,
    input wire logic [31:0] ioBase,
    input wire logic [31:0] ioLimit,
    input wire logic [31:0] memBase,
    input wire logic [31:0] memLimit,
    input wire logic vgaEnable,
    input wire logic isaEnable,
    output logic downHit,
    output logic upHit
);
    function automatic logic inRange(input logic [31:0] a, input logic [31:0] lo,
                                     input logic [31:0] hi);
        inRange = (a >= lo) && (a <= hi);
    endfunction

    logic vgaHit;
    logic ioWin;
    logic memWin;
    logic isaAlias;

    always_comb begin
        vgaHit = (isMem && inRange(addr, bfep_pkg::VGA_MEM_LO, bfep_pkg::VGA_MEM_HI))
            || (isIo && inRange(addr, bfep_pkg::VGA_IO1_LO, bfep_pkg::VGA_IO1_HI))
            || (isIo && inRange(addr, bfep_pkg::VGA_IO2_LO, bfep_pkg::VGA_IO2_HI));
        ioWin = isIo && inRange(addr, ioBase, ioLimit);
        memWin = isMem && inRange(addr, memBase, memLimit);
        // top 768 bytes of a 1K block: offset 0x100..0x3ff
        isaAlias = (addr <= bfep_pkg::ISA_SPACE_TOP) && (addr[9:8] != 2'b00);
        // video ranges win over windows and alias blocking
        downHit = (vgaEnable && vgaHit)
            || (ioWin && !(isaEnable && isaAlias))
            || memWin;
        // video ranges never go upstream while enabled
        upHit = !(vgaEnable && vgaHit)
            && ((isIo && (!ioWin || (isaEnable && isaAlias)))
                || (isMem && !memWin));
    end
endmodule // bfep_fwd_decode

//--- hdl/bfep_err_policy.sv
`timescale 1ns/1ps
module bfep_err_policy (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic masterAbort,
    input wire logic abortIsRead,
    input wire logic abortCompleted,
    input wire logic masterAbortMode,
    input wire logic serrEnable,
    input wire logic serrForward,
    input wire logic secondarySystemErrorIn,
    input wire logic parityResponse,
    input wire logic secAddrParityErr,
    input wire logic secDataParityErr,
    output logic primarySystemErrorOut,
    output logic targetAbortOut,
    output logic abortReadValid,
    output logic [31:0] abortReadData,
    output logic writeDiscardOut,
    output logic secondaryParityErrorOut
);
    logic serrCause;

    always_comb begin
        serrCause = (masterAbort && masterAbortMode && abortCompleted)
            || (secondarySystemErrorIn && serrForward);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            primarySystemErrorOut <= 1'b0;
        end else begin
            // gated by command enable for every cause
            primarySystemErrorOut <= serrCause && serrEnable;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            targetAbortOut <= 1'b0;
            abortReadValid <= 1'b0;
            writeDiscardOut <= 1'b0;
        end else begin
            targetAbortOut <= masterAbort && masterAbortMode && !abortCompleted;
            abortReadValid <= masterAbort && !masterAbortMode && abortIsRead;
            writeDiscardOut <= masterAbort && !masterAbortMode && !abortIsRead;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            abortReadData <= 32'h00000000;
        end else if (masterAbort && !masterAbortMode && abortIsRead) begin
            abortReadData <= bfep_pkg::ABORT_READ_DATA;
        end else begin
            abortReadData <= 32'h00000000;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            secondaryParityErrorOut <= 1'b0;
        end else begin
            secondaryParityErrorOut <= parityResponse
                && (secAddrParityErr || secDataParityErr);
        end
    end
endmodule // bfep_err_policy

//--- hdl/bfep_bridge.sv
`timescale 1ns/1ps
module bfep_bridge (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cfgWrite,
    input wire logic cfgRead,
    input wire logic [7:0] cfgAddr,
    input wire logic [3:0] cfgByteEn,
    input wire logic [31:0] cfgWrData,
    output logic [31:0] cfgRdData,
    output logic cfgRdValid,
    input wire logic d3ToD0,
    input wire logic [31:0] ioBase,
    input wire logic [31:0] ioLimit,
    input wire logic [31:0] memBase,
    input wire logic [31:0] memLimit,
    input wire logic priReq,
    input wire logic [31:0] priAddr,
    input wire logic priIsIo,
    input wire logic priIsMem,
    output logic priClaim,
    input wire logic secReq,
    input wire logic [31:0] secAddr,
    input wire logic secIsIo,
    input wire logic secIsMem,
    input wire logic secIsRead,
    output logic secClaim,
    output logic secPrefetch,
    input wire logic masterAbort,
    input wire logic abortIsRead,
    input wire logic abortCompleted,
    output logic targetAbortOut,
    output logic abortReadValid,
    output logic [31:0] abortReadData,
    output logic writeDiscardOut,
    input wire logic secondary_system_error_in,
    output logic primary_system_error_out,
    input wire logic secAddrParityErr,
    input wire logic secDataParityErr,
    output logic secondary_parity_error_out
);
    logic [15:0] cmdReg_r;
    logic [15:0] bridgePolicyControl_r;
    logic [7:0] chipFunctionControl_r;
    logic [15:0] cmdReg_nxt;
    logic [15:0] bridgePolicyControl_nxt;
    logic [7:0] chipFunctionControl_nxt;
    logic [31:0] rdWord;
    logic downHit;
    logic upHit;
    logic priClaim_nxt;
    logic secClaim_nxt;

    // merge byte lanes under a write mask
    function automatic logic [15:0] mergeHalf(input logic [15:0] old,
                                              input logic [15:0] data,
                                              input logic [1:0] be,
                                              input logic [15:0] wmask);
        logic [15:0] lanes;
        lanes = {{8{be[1]}}, {8{be[0]}}} & wmask;
        mergeHalf = (old & ~lanes) | (data & lanes);
    endfunction

    function automatic logic cfgHit(input logic [7:0] a, input logic [7:0] dw);
        cfgHit = (a[7:2] == dw[7:2]);
    endfunction

    // config write decode
    always_comb begin
        cmdReg_nxt = cmdReg_r;
        bridgePolicyControl_nxt = bridgePolicyControl_r;
        chipFunctionControl_nxt = chipFunctionControl_r;
        if (cfgWrite && cfgHit(cfgAddr, bfep_pkg::CFG_CMD_DW)) begin
            cmdReg_nxt = mergeHalf(cmdReg_r, cfgWrData[15:0], cfgByteEn[1:0],
                                   bfep_pkg::CMD_WMASK);
        end
        if (cfgWrite && cfgHit(cfgAddr, bfep_pkg::CFG_BRCTL_DW)) begin
            // bit 4 is outside the write mask and stays zero
            bridgePolicyControl_nxt = mergeHalf(bridgePolicyControl_r, cfgWrData[31:16],
                                                cfgByteEn[3:2],
                                                bfep_pkg::BC_WMASK);
        end
        if (cfgWrite && cfgByteEn[0] && cfgHit(cfgAddr, bfep_pkg::CFG_CHIPCTL_DW)) begin
            chipFunctionControl_nxt = (chipFunctionControl_r & ~bfep_pkg::CC_WMASK)
                | (cfgWrData[7:0] & bfep_pkg::CC_WMASK);
        end
    end

    // standard header registers fall back to defaults on wake from D3
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmdReg_r <= bfep_pkg::CMD_RESET;
        end else if (d3ToD0) begin
            cmdReg_r <= bfep_pkg::CMD_RESET;
        end else begin
            cmdReg_r <= cmdReg_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bridgePolicyControl_r <= bfep_pkg::BC_RESET;
        end else if (d3ToD0) begin
            bridgePolicyControl_r <= bfep_pkg::BC_RESET;
        end else begin
            bridgePolicyControl_r <= bridgePolicyControl_nxt;
        end
    end

    // extension space ignores the wake strobe, only rst_b clears it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chipFunctionControl_r <= bfep_pkg::CC_RESET;
        end else begin
            chipFunctionControl_r <= chipFunctionControl_nxt;
        end
    end

    // config read mux; unimplemented extension offsets read zero
    always_comb begin
        rdWord = 32'h00000000;
        if (cfgHit(cfgAddr, bfep_pkg::CFG_CMD_DW)) begin
            rdWord = {16'h0000, cmdReg_r};
        end else if (cfgHit(cfgAddr, bfep_pkg::CFG_BRCTL_DW)) begin
            rdWord = {bridgePolicyControl_r & bfep_pkg::BC_WMASK, 16'h0000};
        end else if (cfgHit(cfgAddr, bfep_pkg::CFG_CHIPCTL_DW)) begin
            rdWord = {24'h000000, chipFunctionControl_r & bfep_pkg::CC_WMASK};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfgRdData <= 32'h00000000;
            cfgRdValid <= 1'b0;
        end else begin
            cfgRdData <= cfgRead ? rdWord : 32'h00000000;
            cfgRdValid <= cfgRead;
        end
    end

    // one decoder serves both directions; each side uses its own half
    logic [31:0] decAddr;
    logic decIo;
    logic decMem;

    // primary has priority when both sides present an address at once
    always_comb begin
        decAddr = priReq ? priAddr : secAddr;
        decIo = priReq ? priIsIo : secIsIo;
        decMem = priReq ? priIsMem : secIsMem;
    end

    bfep_fwd_decode bfep_fwd_decode_inst (
        .addr(decAddr),
        .isIo(decIo),
        .isMem(decMem),
        .ioBase(ioBase),
        .ioLimit(ioLimit),
        .memBase(memBase),
        .memLimit(memLimit),
        .vgaEnable(bridgePolicyControl_r[bfep_pkg::BC_VGA_BIT]),
        .isaEnable(bridgePolicyControl_r[bfep_pkg::BC_ISA_BIT]),
        .downHit(downHit),
        .upHit(upHit)
    );

    always_comb begin
        priClaim_nxt = priReq && downHit;
        secClaim_nxt = !priReq && secReq && upHit;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            priClaim <= 1'b0;
            secClaim <= 1'b0;
            secPrefetch <= 1'b0;
        end else begin
            priClaim <= priClaim_nxt;
            secClaim <= secClaim_nxt;
            secPrefetch <= secClaim_nxt && secIsMem && secIsRead
                && !chipFunctionControl_r[bfep_pkg::CC_PREFETCH_OFF_BIT];
        end
    end

    bfep_err_policy bfep_err_policy_inst (
        .clk(clk),
        .rst_b(rst_b),
        .masterAbort(masterAbort),
        .abortIsRead(abortIsRead),
        .abortCompleted(abortCompleted),
        .masterAbortMode(bridgePolicyControl_r[bfep_pkg::BC_MAMODE_BIT]),
        .serrEnable(cmdReg_r[bfep_pkg::CMD_SERR_EN_BIT]),
        .serrForward(bridgePolicyControl_r[bfep_pkg::BC_SERR_FWD_BIT]),
        .secondarySystemErrorIn(secondary_system_error_in),
        .parityResponse(bridgePolicyControl_r[bfep_pkg::BC_PARITY_BIT]),
        .secAddrParityErr(secAddrParityErr),
        .secDataParityErr(secDataParityErr),
        .primarySystemErrorOut(primary_system_error_out),
        .targetAbortOut(targetAbortOut),
        .abortReadValid(abortReadValid),
        .abortReadData(abortReadData),
        .writeDiscardOut(writeDiscardOut),
        .secondaryParityErrorOut(secondary_parity_error_out)
    );
endmodule // bfep_bridge

//--- bench/bfep_bridge_props.sv
`timescale 1ns/1ps
module bfep_bridge_chk (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cfgRead,
    input wire logic cfgRdValid,
    input wire logic [31:0] cfgRdData,
    input wire logic priReq,
    input wire logic priClaim,
    input wire logic secReq,
    input wire logic secIsMem,
    input wire logic secIsRead,
    input wire logic secClaim,
    input wire logic secPrefetch,
    input wire logic masterAbort,
    input wire logic abortIsRead,
    input wire logic abortCompleted,
    input wire logic targetAbortOut,
    input wire logic abortReadValid,
    input wire logic [31:0] abortReadData,
    input wire logic writeDiscardOut,
    input wire logic secondary_system_error_in,
    input wire logic primary_system_error_out,
    input wire logic secAddrParityErr,
    input wire logic secDataParityErr,
    input wire logic secondary_parity_error_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence abortRdSeq;
        masterAbort && abortIsRead ##1 abortReadValid;
    endsequence
    sequence cfgRdSeq;
        cfgRead ##1 cfgRdValid;
    endsequence
    rd_answer_a: assert property (cfgRead |=> cfgRdValid) else $error("read not answered");
    rd_idle_a: assert property (!cfgRdValid |-> cfgRdData == 32'h0) else $error("stray read data");
    rd_cause_a: assert property (cfgRdValid |-> $past(cfgRead)) else $error("read answer without request");
    abort_ones_a: assert property (abortRdSeq |-> abortReadData == 32'hffffffff) else $error("abort read data");
    abort_rdcause_a: assert property (abortReadValid |-> $past(masterAbort && abortIsRead)) else $error("abort read cause");
    drop_write_a: assert property (writeDiscardOut |-> $past(masterAbort && !abortIsRead)) else $error("write drop cause");
    tgt_abort_a: assert property (targetAbortOut |-> $past(masterAbort && !abortCompleted)) else $error("target abort cause");
    abort_excl_a: assert property (targetAbortOut |-> !abortReadValid && !writeDiscardOut) else $error("abort both ways");
    serr_cause_a: assert property (primary_system_error_out |-> $past(secondary_system_error_in || masterAbort && abortCompleted)) else $error("system error cause");
    parity_cause_a: assert property (secondary_parity_error_out |-> $past(secAddrParityErr || secDataParityErr)) else $error("parity report cause");
    up_claim_a: assert property (secClaim || secPrefetch |-> $past(secReq && !priReq)) else $error("upstream claim cause");
    prefetch_kind_a: assert property (secPrefetch |-> $past(secIsMem && secIsRead)) else $error("prefetch not mem read");
    down_claim_a: assert property (priClaim |-> $past(priReq)) else $error("downstream claim cause");
    cover property (cfgRdSeq);
endmodule // bfep_bridge_chk
bind bfep_bridge bfep_bridge_chk bfep_bridge_chk_inst (.clk, .rst_b, .cfgRead, .cfgRdValid,
    .cfgRdData, .priReq, .priClaim, .secReq, .secIsMem, .secIsRead, .secClaim, .secPrefetch,
    .masterAbort, .abortIsRead, .abortCompleted, .targetAbortOut, .abortReadValid,
    .abortReadData, .writeDiscardOut, .secondary_system_error_in, .primary_system_error_out,
    .secAddrParityErr, .secDataParityErr, .secondary_parity_error_out);

//--- bench/bfep_sec_agent.sv
`timescale 1ns/1ps
module bfep_sec_agent (
    input wire logic clk,
    output logic secReq,
    output logic [31:0] secAddr,
    output logic secIsIo,
    output logic secIsMem,
    output logic secIsRead,
    output logic secondary_system_error_in,
    output logic secAddrParityErr,
    output logic secDataParityErr,
    output logic masterAbort,
    output logic abortIsRead,
    output logic abortCompleted
);
    initial begin
        {secReq, secIsIo, secIsMem, secIsRead, masterAbort, abortIsRead, abortCompleted} = '0;
        {secondary_system_error_in, secAddrParityErr, secDataParityErr} = '0;
        secAddr = 32'h0;
    end
    // each task idles one edge first so a strobe never drops and rises in one step
    // address phase; released address turns inverse so a stale value never looks valid
    task up(input logic [31:0] a, input logic io, input logic r);
        @(negedge clk);
        {secReq, secAddr, secIsIo, secIsMem, secIsRead} = {1'b1, a, io, !io, r};
        @(negedge clk);
        {secReq, secIsIo, secIsMem, secIsRead} = '0;
        secAddr = ~a;
    endtask
    // one-cycle event: 0 system error, 1 address parity, 2 data parity
    task ev(input int k);
        @(negedge clk);
        {secondary_system_error_in, secAddrParityErr, secDataParityErr} = 3'h4 >> k;
        @(negedge clk);
        {secondary_system_error_in, secAddrParityErr, secDataParityErr} = '0;
    endtask
    // far target does not answer: bridge sees master abort
    task ma(input logic rd, input logic done);
        @(negedge clk);
        {masterAbort, abortIsRead, abortCompleted} = {1'b1, rd, done};
        @(negedge clk);
        {masterAbort, abortIsRead, abortCompleted} = '0;
    endtask
endmodule // bfep_sec_agent

//--- bench/test_bridge_forwarding_error_policy.sv
`timescale 1ns/1ps
module test_bridge_forwarding_error_policy;
    logic clk = 1'b0, rst_b = 1'b0, cfgWrite = 1'b0, cfgRead = 1'b0, d3ToD0 = 1'b0;
    logic [7:0] cfgAddr = 8'h0;
    logic [3:0] cfgByteEn = 4'h0;
    logic [31:0] cfgWrData = 32'h0, cfgRdData, abortReadData, priAddr = 32'h0;
    logic [31:0] ioBase = 32'h1000, ioLimit = 32'h1fff, memBase = 32'h10000000;
    logic [31:0] memLimit = 32'h1fffffff, secAddr;
    logic priReq = 1'b0, priIsIo = 1'b0, priIsMem = 1'b0;
    logic cfgRdValid, priClaim, secReq, secIsIo, secIsMem, secIsRead, secClaim, secPrefetch;
    logic masterAbort, abortIsRead, abortCompleted, targetAbortOut, abortReadValid;
    logic writeDiscardOut, secondary_system_error_in, primary_system_error_out;
    logic secAddrParityErr, secDataParityErr, secondary_parity_error_out;
    int error_cnt = 0, num_checks = 0;
    logic [31:0] vgaTbl [6] = '{32'h000a0000, 32'h000bffff, 32'h3b0, 32'h3bb, 32'h3c0, 32'h3df};
    always #20 clk = ~clk;
    bfep_bridge bfep_bridge_inst (.clk, .rst_b, .cfgWrite, .cfgRead, .cfgAddr, .cfgByteEn,
        .cfgWrData, .cfgRdData, .cfgRdValid, .d3ToD0, .ioBase, .ioLimit, .memBase, .memLimit,
        .priReq, .priAddr, .priIsIo, .priIsMem, .priClaim, .secReq, .secAddr, .secIsIo,
        .secIsMem, .secIsRead, .secClaim, .secPrefetch, .masterAbort, .abortIsRead,
        .abortCompleted, .targetAbortOut, .abortReadValid, .abortReadData, .writeDiscardOut,
        .secondary_system_error_in, .primary_system_error_out, .secAddrParityErr,
        .secDataParityErr, .secondary_parity_error_out);
    bfep_sec_agent bfep_sec_agent_inst (.clk, .secReq, .secAddr, .secIsIo, .secIsMem,
        .secIsRead, .secondary_system_error_in, .secAddrParityErr, .secDataParityErr,
        .masterAbort, .abortIsRead, .abortCompleted);
    task finish_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge clk);
        {cfgWrite, cfgAddr, cfgByteEn, cfgWrData} = {1'b1, a, be, d};
        @(negedge clk);
        cfgWrite = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(negedge clk);
        {cfgRead, cfgAddr} = {1'b1, a};
        @(negedge clk);
        cfgRead = 1'b0;
        chk({31'h0, cfgRdValid}, 32'h1);
        chk(cfgRdData, e);
    endtask
    task bc(input logic [15:0] v);
        wr(8'h3c, 4'hc, {v, 16'h0});
    endtask
    task pri(input logic [31:0] a, input logic io, input logic e);
        @(negedge clk);
        {priReq, priAddr, priIsIo, priIsMem} = {1'b1, a, io, !io};
        @(negedge clk);
        {priReq, priIsIo, priIsMem} = '0;
        priAddr = ~a;
        chk({31'h0, priClaim}, {31'h0, e});
    endtask
    task up(input logic [31:0] a, input logic io, input logic ec, input logic ep);
        bfep_sec_agent_inst.up(a, io, 1'b1);
        chk({30'h0, secClaim, secPrefetch}, {30'h0, ec, ep});
    endtask
    initial begin
        repeat (4000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk) rst_b = 1'b1;
        rd(8'h04, 32'h0);
        rd(8'h3c, 32'h0);
        rd(8'h40, 32'h0);
        wr(8'h40, 4'hf, 32'hffffffff);
        rd(8'h40, 32'h12);
        wr(8'h44, 4'hf, 32'hffffffff);
        rd(8'h44, 32'h0);
        bc(16'hffff);
        rd(8'h3c, 32'h0b6f0000);
        d3ToD0 = 1'b1;
        @(negedge clk) d3ToD0 = 1'b0;
        rd(8'h40, 32'h12);
        rd(8'h3c, 32'h0);
        pri(32'h000a0000, 1'b0, 1'b0);
        bc(16'h0008);
        for (int i = 0; i < 6; i++) pri(vgaTbl[i], i > 1, 1'b1);
        pri(32'h3bc, 1'b1, 1'b0);
        up(32'h000a0000, 1'b0, 1'b0, 1'b0);
        up(32'h3c0, 1'b1, 1'b0, 1'b0);
        bc(16'h0000);
        up(32'h000a0000, 1'b0, 1'b1, 1'b0);
        wr(8'h40, 4'h1, 32'h0);
        up(32'h000a0000, 1'b0, 1'b1, 1'b1);
        bfep_sec_agent_inst.up(32'h000a0000, 1'b0, 1'b0);
        chk({30'h0, secClaim, secPrefetch}, 32'h2);
        pri(32'h1100, 1'b1, 1'b1);
        bc(16'h0004);
        pri(32'h1100, 1'b1, 1'b0);
        pri(32'h13ff, 1'b1, 1'b0);
        pri(32'h1000, 1'b1, 1'b1);
        up(32'h1100, 1'b1, 1'b1, 1'b0);
        bc(16'h0000);
        bfep_sec_agent_inst.ma(1'b1, 1'b0);
        chk({31'h0, abortReadValid}, 32'h1);
        chk(abortReadData, 32'hffffffff);
        bfep_sec_agent_inst.ma(1'b0, 1'b1);
        chk({30'h0, writeDiscardOut, primary_system_error_out}, 32'h2);
        bc(16'h0020);
        bfep_sec_agent_inst.ma(1'b0, 1'b0);
        chk({30'h0, targetAbortOut, writeDiscardOut}, 32'h2);
        bfep_sec_agent_inst.ma(1'b0, 1'b1);
        chk({31'h0, primary_system_error_out}, 32'h0);
        wr(8'h04, 4'h3, 32'h100);
        bfep_sec_agent_inst.ma(1'b0, 1'b1);
        chk({31'h0, primary_system_error_out}, 32'h1);
        bfep_sec_agent_inst.ev(0);
        chk({31'h0, primary_system_error_out}, 32'h0);
        bc(16'h0002);
        bfep_sec_agent_inst.ev(0);
        chk({31'h0, primary_system_error_out}, 32'h1);
        wr(8'h04, 4'h3, 32'h0);
        bfep_sec_agent_inst.ev(0);
        chk({31'h0, primary_system_error_out}, 32'h0);
        bfep_sec_agent_inst.ev(1);
        chk({31'h0, secondary_parity_error_out}, 32'h0);
        bc(16'h0001);
        for (int k = 1; k < 3; k++) begin
            bfep_sec_agent_inst.ev(k);
            chk({31'h0, secondary_parity_error_out}, 32'h1);
        end
        bc(16'h0008);
        wr(8'h40, 4'h1, 32'h10);
        // mid-run reset: outputs low while held, registers back to defaults after
        rst_b = 1'b0;
        @(negedge clk);
        chk({23'h0, cfgRdValid, priClaim, secClaim, secPrefetch, targetAbortOut, abortReadValid,
            writeDiscardOut, primary_system_error_out, secondary_parity_error_out}, 32'h0);
        rst_b = 1'b1;
        rd(8'h3c, 32'h0);
        rd(8'h40, 32'h0);
        finish_test();
    end
endmodule // test_bridge_forwarding_error_policy
